// File: rtl/viu_core.sv
// vectored interrupt unit: request collection, classing and arbitration
`timescale 1ns/1ps
`default_nettype none
module viu_core (
   input  wire logic                         sys_clk,      // 50 MHz
   input  wire logic                         nrst,         // async, low
   // class and enable configuration
   input  wire logic [viu_pkg::NUM_CH-1:0]   fast_select,  // 1 = fast
   input  wire logic [viu_pkg::NUM_CH-1:0]   int_enable,   // 1 = on
   // slot configuration write port
   input  wire logic                         slot_wr,      // write strobe
   input  wire logic [viu_pkg::SLOT_W-1:0]   slot_wr_index,// slot number
   input  wire logic [viu_pkg::ADDR_W-1:0]   slot_wr_addr, // routine addr
   input  wire logic [viu_pkg::CH_W-1:0]     slot_wr_chan, // source chan
   input  wire logic                         slot_wr_en,   // slot enable
   input  wire logic                         default_wr,   // write strobe
   input  wire logic [viu_pkg::ADDR_W-1:0]   default_addr, // default addr
   // sources
   input  wire logic                         watchdog_flag,     // ch 0
   input  wire logic                         soft_request,      // ch 1
   input  wire logic                         dbg_rx_req,        // ch 2
   input  wire logic                         dbg_tx_req,        // ch 3
   input  wire logic [3:0]                   t0_match_zero,     // ch 4
   input  wire logic [3:0]                   t0_capture_zero,   // ch 4
   input  wire logic [3:0]                   t1_match_zero,     // ch 5
   input  wire logic [3:0]                   t1_capture_zero,   // ch 5
   input  wire logic                         s0_line_status_flag,     // 6
   input  wire logic                         s0_transmit_empty_flag,  // 6
   input  wire logic                         s0_receive_available_flag, // 6
   input  wire logic                         s0_char_timeout_flag,    // 6
   input  wire logic                         s0_autobaud_timeout_flag, // 6
   input  wire logic                         s0_autobaud_end_flag,    // 6
   input  wire logic                         s1_line_status_flag,     // 7
   input  wire logic                         s1_transmit_empty_flag,  // 7
   input  wire logic                         s1_receive_available_flag, // 7
   input  wire logic                         s1_char_timeout_flag,    // 7
   input  wire logic                         s1_modem_status_flag,    // 7
   input  wire logic                         s1_autobaud_timeout_flag, // 7
   input  wire logic                         s1_autobaud_end_flag,    // 7
   input  wire logic [6:0]                   pwm_match_flags,   // ch 8
   input  wire logic                         two_wire_state_flag,// ch 9
   input  wire logic                         spi0_transfer_done_flag, // 10
   input  wire logic                         spi0_mode_fault_flag,    // 10
   input  wire logic                         spi1_transfer_done_flag, // 11
   input  wire logic                         spi1_mode_fault_flag,    // 11
   input  wire logic                         tx_half_empty_flag, // ch 11
   input  wire logic                         rx_half_full_flag,  // ch 11
   input  wire logic                         rx_timeout_flag,    // ch 11
   input  wire logic                         rx_overrun_flag,    // ch 11
   input  wire logic                         multiplier_lock_flag,// 12
   input  wire logic                         counter_increment_flag, // 13
   input  wire logic                         alarm_flag,         // ch 13
   input  wire logic                         ext_request_zero,   // pin
   input  wire logic                         ext_request_one,    // pin
   input  wire logic                         ext_request_two,    // pin
   input  wire logic                         ext_request_three,  // pin
   input  wire logic                         conv_done_flag,     // ch 18
   input  wire logic                         accept_filter_flag, // ch 19
   input  wire logic                         can1_tx_flag,       // ch 20
   input  wire logic                         can1_rx_flag,       // ch 21
   input  wire logic                         can2_tx_flag,       // ch 22
   input  wire logic                         can2_rx_flag,       // ch 23
   // towards the processor and software
   output logic                              fast_request,   // core input
   output logic                              normal_request, // core input
   output logic [viu_pkg::NUM_CH-1:0]        raw_status,     // raw lines
   output logic [viu_pkg::NUM_CH-1:0]        fast_status,    // fast active
   output logic [viu_pkg::NUM_CH-1:0]        normal_status,  // normal act
   output logic [viu_pkg::ADDR_W-1:0]        vector_addr,    // routine
   output logic                              vector_valid,   // slot won
   output logic [viu_pkg::SLOT_W-1:0]        vector_slot     // winner
);
   import viu_pkg::*;

   // =====================================================
   // external request synchronisers
   logic [NUM_EXT-1:0] ext_meta_reg;
   logic [NUM_EXT-1:0] ext_sync_reg;
   wire  [NUM_EXT-1:0] ext_pins = {ext_request_three, ext_request_two,
                                   ext_request_one, ext_request_zero};

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ext_meta_reg <= '0;
         ext_sync_reg <= '0;
      end else begin
         ext_meta_reg <= ext_pins;
         ext_sync_reg <= ext_meta_reg;
      end
   end

   // =====================================================
   // merged request lines, one per channel
   wire [NUM_CH-1:0] raw_next;
   assign raw_next[CH_WATCHDOG]  = watchdog_flag;
   assign raw_next[CH_SOFT]      = soft_request;
   assign raw_next[CH_DBG_RX]    = dbg_rx_req;
   assign raw_next[CH_DBG_TX]    = dbg_tx_req;
   assign raw_next[CH_TIMER0]    = |{t0_match_zero, t0_capture_zero};
   assign raw_next[CH_TIMER1]    = |{t1_match_zero, t1_capture_zero};
   assign raw_next[CH_SERIAL0]   = |{s0_line_status_flag,
                                     s0_transmit_empty_flag,
                                     s0_receive_available_flag,
                                     s0_char_timeout_flag,
                                     s0_autobaud_timeout_flag,
                                     s0_autobaud_end_flag};
   assign raw_next[CH_SERIAL1]   = |{s1_line_status_flag,
                                     s1_transmit_empty_flag,
                                     s1_receive_available_flag,
                                     s1_char_timeout_flag,
                                     s1_modem_status_flag,
                                     s1_autobaud_timeout_flag,
                                     s1_autobaud_end_flag};
   assign raw_next[CH_PWM]       = |pwm_match_flags;
   assign raw_next[CH_TWO_WIRE]  = two_wire_state_flag;
   assign raw_next[CH_SPI0]      = spi0_transfer_done_flag
                                 | spi0_mode_fault_flag;
   // both sources share the pins, so either may be live
   assign raw_next[CH_SPI1]      = |{spi1_transfer_done_flag,
                                     spi1_mode_fault_flag,
                                     tx_half_empty_flag,
                                     rx_half_full_flag,
                                     rx_timeout_flag,
                                     rx_overrun_flag};
   assign raw_next[CH_MULT_LOCK] = multiplier_lock_flag;
   assign raw_next[CH_RTC]       = counter_increment_flag
                                 | alarm_flag;
   assign raw_next[CH_EXT_FIRST +: NUM_EXT] = ext_sync_reg;
   assign raw_next[CH_CONVERTER] = conv_done_flag;
   assign raw_next[CH_ACCEPT]    = accept_filter_flag;
   assign raw_next[CH_CAN1_TX]   = can1_tx_flag;
   assign raw_next[CH_CAN1_RX]   = can1_rx_flag;
   assign raw_next[CH_CAN2_TX]   = can2_tx_flag;
   assign raw_next[CH_CAN2_RX]   = can2_rx_flag;
   assign raw_next[NUM_CH-1:CH_USED] = '0;

   // =====================================================
   // classing, from the registered raw lines
   wire [NUM_CH-1:0] active      = raw_status & int_enable;
   wire [NUM_CH-1:0] fast_next   = active & fast_select;
   wire [NUM_CH-1:0] normal_next = active & ~fast_select;

   // =====================================================
   // slot storage and hits
   logic [ADDR_W-1:0] slot_addr_reg [NUM_SLOTS];
   logic [CH_W-1:0]   slot_chan_reg [NUM_SLOTS];
   logic              slot_en_reg   [NUM_SLOTS];
   logic [ADDR_W-1:0] default_reg;
   wire  [NUM_SLOTS-1:0] slot_hit;

   genvar gs;
   generate
      for (gs = 0; gs < NUM_SLOTS; gs++) begin : g_slot
         wire sel = slot_wr && (slot_wr_index == SLOT_W'(gs));
         always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
               slot_addr_reg[gs] <= RST_ADDR;
               slot_chan_reg[gs] <= RST_CHANNEL;
               slot_en_reg[gs]   <= 1'b0;
            end else if (sel) begin
               slot_addr_reg[gs] <= slot_wr_addr;
               slot_chan_reg[gs] <= slot_wr_chan;
               slot_en_reg[gs]   <= slot_wr_en;
            end
         end
         // fast channels cannot win a slot
         assign slot_hit[gs] = slot_en_reg[gs]
                             && normal_next[slot_chan_reg[gs]];
      end
   endgenerate

   // =====================================================
   // priority: lowest slot number wins
   logic              hit_any;
   logic [SLOT_W-1:0] hit_idx;
   always_comb begin
      hit_any = 1'b0;
      hit_idx = RST_SLOT;
      for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
         if (slot_hit[i]) begin
            hit_any = 1'b1;
            hit_idx = SLOT_W'(i);
         end
      end
   end

   // vectored beats plain; plain gets the shared default
   wire [ADDR_W-1:0] vaddr_next = hit_any ? slot_addr_reg[hit_idx]
                                          : default_reg;

   // slots that outrank the winner, for the priority check
   wire [NUM_SLOTS-1:0] win_below = (NUM_SLOTS'(1) << hit_idx)
                                  - NUM_SLOTS'(1);

   // =====================================================
   // registered outputs
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         default_reg <= RST_ADDR;
      end else if (default_wr) begin
         default_reg <= default_addr;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         raw_status     <= RST_WORD;
         fast_status    <= RST_WORD;
         normal_status  <= RST_WORD;
         fast_request   <= 1'b0;
         normal_request <= 1'b0;
         vector_addr    <= RST_ADDR;
         vector_valid   <= 1'b0;
         vector_slot    <= RST_SLOT;
      end else begin
         raw_status     <= raw_next;
         fast_status    <= fast_next;
         normal_status  <= normal_next;
         fast_request   <= |fast_next;
         normal_request <= |normal_next;
         vector_addr    <= vaddr_next;
         vector_valid   <= hit_any;
         vector_slot    <= hit_idx;
      end
   end

   // =====================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   AST_FAST_MERGE: assert property (
      fast_request == (|fast_status))
      else $error("fast output disagrees with fast status");

   AST_NORMAL_MERGE: assert property (
      normal_request == (|normal_status))
      else $error("normal output disagrees with normal status");

   AST_CLASS_EXCL: assert property (
      (fast_status & normal_status) == RST_WORD)
      else $error("channel in both fast and normal status");

   AST_FAST_SRC: assert property (
      $past(raw_status[CH_WATCHDOG] && int_enable[CH_WATCHDOG]
            && fast_select[CH_WATCHDOG]) |-> fast_status[CH_WATCHDOG])
      else $error("fast watchdog request missing from fast status");

   AST_EXT_PATH: assert property (
      ext_request_two && int_enable[CH_EXT_FIRST + 2]
      && !fast_select[CH_EXT_FIRST + 2]
      ##1 int_enable[CH_EXT_FIRST + 2] && !fast_select[CH_EXT_FIRST + 2]
      ##1 int_enable[CH_EXT_FIRST + 2] && !fast_select[CH_EXT_FIRST + 2]
      ##1 int_enable[CH_EXT_FIRST + 2] && !fast_select[CH_EXT_FIRST + 2]
      |=> normal_status[CH_EXT_FIRST + 2])
      else $error("external request two not seen on its channel");

   AST_TIMER_MERGE: assert property (
      t1_capture_zero[3] |=> raw_status[CH_TIMER1])
      else $error("timer capture not merged onto its channel");

   AST_SOFT_ONLY: assert property (
      !soft_request |=> !raw_status[CH_SOFT])
      else $error("software channel set without software");

   AST_SLOT0_WINS: assert property (
      slot_hit[0] |=> vector_valid && vector_slot == RST_SLOT)
      else $error("slot zero did not win arbitration");

   AST_DEFAULT_ADDR: assert property (
      !hit_any |=> !vector_valid && vector_addr == $past(default_reg))
      else $error("default address not given without a vector");

   AST_SLOT_ADDR: assert property (
      hit_any |=> vector_addr == $past(slot_addr_reg[hit_idx]))
      else $error("vector address not from winning slot");

   AST_UNUSED_CH: assert property (
      raw_status[NUM_CH-1:CH_USED] == '0)
      else $error("unused channel shows a request");

   AST_ENABLE_GATE: assert property (
      ((fast_status | normal_status) & ~$past(int_enable)) == RST_WORD)
      else $error("disabled channel shows in status");

   AST_SPLIT: assert property (
      (normal_status & $past(fast_select)) == RST_WORD)
      else $error("fast channel shows in normal status");

   AST_PRIORITY: assert property (
      hit_any |-> slot_hit[hit_idx] && ((slot_hit & win_below) == '0))
      else $error("a higher slot was passed over");

   AST_WATCHDOG_MAP: assert property (
      watchdog_flag |=> raw_status[CH_WATCHDOG])
      else $error("watchdog flag not on its channel");

   AST_SERIAL0_MERGE: assert property (
      s0_autobaud_end_flag |=> raw_status[CH_SERIAL0])
      else $error("first serial flag not merged onto its channel");

   AST_MODEM_MERGE: assert property (
      s1_modem_status_flag |=> raw_status[CH_SERIAL1])
      else $error("modem status not merged onto its channel");

   AST_PWM_MERGE: assert property (
      pwm_match_flags[6] |=> raw_status[CH_PWM])
      else $error("pulse-width match not merged onto its channel");

   AST_SPI0_MERGE: assert property (
      spi0_mode_fault_flag |=> raw_status[CH_SPI0])
      else $error("first SPI fault not merged onto its channel");

   AST_SYNC_PORT_MERGE: assert property (
      rx_overrun_flag |=> raw_status[CH_SPI1])
      else $error("synchronous port overrun not on its channel");

   AST_RTC_MERGE: assert property (
      alarm_flag |=> raw_status[CH_RTC])
      else $error("clock alarm not merged onto its channel");

   AST_CAN_MAP: assert property (
      can2_rx_flag |=> raw_status[CH_CAN2_RX])
      else $error("second CAN receive not on its channel");
endmodule
`default_nettype wire

// File: rtl/viu_pkg.sv
// constants shared by the vectored interrupt unit
package viu_pkg;
   // =====================================================
   // geometry
   localparam int NUM_CH    = 32;
   localparam int CH_W      = 5;
   localparam int NUM_SLOTS = 16;
   localparam int SLOT_W    = 4;
   localparam int ADDR_W    = 32;

   // =====================================================
   // channel positions
   localparam int CH_WATCHDOG   = 0;
   localparam int CH_SOFT       = 1;
   localparam int CH_DBG_RX     = 2;
   localparam int CH_DBG_TX     = 3;
   localparam int CH_TIMER0     = 4;
   localparam int CH_TIMER1     = 5;
   localparam int CH_SERIAL0    = 6;
   localparam int CH_SERIAL1    = 7;
   localparam int CH_PWM        = 8;
   localparam int CH_TWO_WIRE   = 9;
   localparam int CH_SPI0       = 10;
   localparam int CH_SPI1       = 11;
   localparam int CH_MULT_LOCK  = 12;
   localparam int CH_RTC        = 13;
   localparam int CH_EXT_FIRST  = 14;
   localparam int NUM_EXT       = 4;
   localparam int CH_CONVERTER  = 18;
   localparam int CH_ACCEPT     = 19;
   localparam int CH_CAN1_TX    = 20;
   localparam int CH_CAN1_RX    = 21;
   localparam int CH_CAN2_TX    = 22;
   localparam int CH_CAN2_RX    = 23;
   localparam int CH_USED       = 24;

   // =====================================================
   // reset values
   localparam logic [ADDR_W-1:0] RST_ADDR    = 32'h0000_0000;
   localparam logic [CH_W-1:0]   RST_CHANNEL = 5'h00;
   localparam logic [NUM_CH-1:0] RST_WORD    = 32'h0000_0000;
   localparam logic [SLOT_W-1:0] RST_SLOT    = 4'h0;
endpackage

// File: dv/viu_core_model.sv
// processor core side model: picks the handler the interrupt lines ask for
`timescale 1ns/1ps
`default_nettype none
module viu_core_model (
   input  wire logic                       sys_clk,        // system clock
   input  wire logic                       nrst,           // async, low
   input  wire logic                       fast_request,   // fast line
   input  wire logic                       normal_request, // normal line
   input  wire logic [viu_pkg::ADDR_W-1:0] vector_addr,    // routine addr
   output logic      [1:0]                 core_mode,      // 0 off,1 nrm,2 fst
   output logic      [viu_pkg::ADDR_W-1:0] jump_addr       // fetched vector
);
   import viu_pkg::*;
   // =====================================================
   // handler entry
   // the core fetches the vector only on the normal path
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         core_mode <= 2'h0;
         jump_addr <= RST_ADDR;
      end else if (fast_request) begin
         core_mode <= 2'h2;
      end else if (normal_request) begin
         core_mode <= 2'h1;
         jump_addr <= vector_addr;
      end else begin
         core_mode <= 2'h0;
      end
   end
endmodule
`default_nettype wire

// File: dv/viu_core_tb_top.sv
// self-checking bench for the vectored interrupt unit
`timescale 1ns/1ps
`default_nettype none
module viu_core_tb_top;
   import viu_pkg::*;
   localparam int LIMIT = 3000;
   localparam logic [31:0] DEF_A = 32'h0000_D000;
   logic              sys_clk, nrst, slot_wr, slot_wr_en, default_wr;
   logic [61:0]       src;
   logic [NUM_CH-1:0] fast_select, int_enable, raw_status, fast_status;
   logic [NUM_CH-1:0] normal_status;
   logic [SLOT_W-1:0] slot_wr_index, vector_slot;
   logic [CH_W-1:0]   slot_wr_chan;
   logic [ADDR_W-1:0] slot_wr_addr, default_addr, vector_addr, jump_addr;
   logic              fast_request, normal_request, vector_valid;
   logic [1:0]        core_mode;
   logic [31:0]       exp;
   int                miscompares, comparisons, cycles, i;

   viu_core i_dut (.sys_clk(sys_clk), .nrst(nrst),
      .fast_select(fast_select), .int_enable(int_enable),
      .slot_wr(slot_wr), .slot_wr_index(slot_wr_index),
      .slot_wr_addr(slot_wr_addr), .slot_wr_chan(slot_wr_chan),
      .slot_wr_en(slot_wr_en), .default_wr(default_wr),
      .default_addr(default_addr), .watchdog_flag(src[0]),
      .soft_request(src[1]), .dbg_rx_req(src[2]), .dbg_tx_req(src[3]),
      .t0_match_zero(src[7:4]), .t0_capture_zero(src[11:8]),
      .t1_match_zero(src[15:12]), .t1_capture_zero(src[19:16]),
      .s0_line_status_flag(src[20]), .s0_transmit_empty_flag(src[21]),
      .s0_receive_available_flag(src[22]), .s0_char_timeout_flag(src[23]),
      .s0_autobaud_timeout_flag(src[24]), .s0_autobaud_end_flag(src[25]),
      .s1_line_status_flag(src[26]), .s1_transmit_empty_flag(src[27]),
      .s1_receive_available_flag(src[28]), .s1_char_timeout_flag(src[29]),
      .s1_modem_status_flag(src[30]), .s1_autobaud_timeout_flag(src[31]),
      .s1_autobaud_end_flag(src[32]), .pwm_match_flags(src[39:33]),
      .two_wire_state_flag(src[40]), .spi0_transfer_done_flag(src[41]),
      .spi0_mode_fault_flag(src[42]), .spi1_transfer_done_flag(src[43]),
      .spi1_mode_fault_flag(src[44]), .tx_half_empty_flag(src[45]),
      .rx_half_full_flag(src[46]), .rx_timeout_flag(src[47]),
      .rx_overrun_flag(src[48]), .multiplier_lock_flag(src[49]),
      .counter_increment_flag(src[50]), .alarm_flag(src[51]),
      .conv_done_flag(src[52]), .accept_filter_flag(src[53]),
      .can1_tx_flag(src[54]), .can1_rx_flag(src[55]),
      .can2_tx_flag(src[56]), .can2_rx_flag(src[57]),
      .ext_request_zero(src[58]), .ext_request_one(src[59]),
      .ext_request_two(src[60]), .ext_request_three(src[61]),
      .fast_request(fast_request), .normal_request(normal_request),
      .raw_status(raw_status), .fast_status(fast_status),
      .normal_status(normal_status), .vector_addr(vector_addr),
      .vector_valid(vector_valid), .vector_slot(vector_slot));

   viu_core_model i_core (.sys_clk(sys_clk), .nrst(nrst),
      .fast_request(fast_request), .normal_request(normal_request),
      .vector_addr(vector_addr), .core_mode(core_mode),
      .jump_addr(jump_addr));

   // =====================================================
   // clock, watchdog on the run
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         miscompares++;
         finish_test();
      end
   end

   // =====================================================
   // helpers
   function automatic int chan_of(input int b);
      if (b < 4) return b;
      if (b < 58 && b > 51) return (b < 54) ? b - 34 : b - 34;
      if (b < 12) return 4;
      if (b < 20) return 5;
      if (b < 26) return 6;
      if (b < 33) return 7;
      if (b < 40) return 8;
      if (b < 41) return 9;
      if (b < 43) return 10;
      if (b < 49) return 11;
      if (b < 50) return 12;
      if (b < 52) return 13;
      return b - 44; // external pins land on 14..17
   endfunction
   task automatic chk_word(input logic [31:0] got, input logic [31:0] want);
      comparisons++;
      if (got !== want) begin
         miscompares++;
         $display("ERROR %0t word %h expected %h", $time, got, want);
      end
   endtask
   task automatic chk_bit(input logic got, input logic want);
      comparisons++;
      if (got !== want) begin
         miscompares++;
         $display("ERROR %0t bit %b expected %b", $time, got, want);
      end
   endtask
   // covers the slowest path, the synchronised external pins
   task automatic settle();
      repeat (6) @(negedge sys_clk);
   endtask
   task automatic wr_slot(input logic [SLOT_W-1:0] idx,
                          input logic [CH_W-1:0] ch, input logic en,
                          input logic [ADDR_W-1:0] a);
      @(negedge sys_clk);
      slot_wr = 1'b1;
      slot_wr_index = idx;
      slot_wr_chan = ch;
      slot_wr_en = en;
      slot_wr_addr = a;
      @(negedge sys_clk);
      slot_wr = 1'b0;
   endtask
   task automatic finish_test();
      if (miscompares == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // =====================================================
   // main sequence
   initial begin
      cycles = 0; miscompares = 0; comparisons = 0;
      nrst = 1'b0; src = '0; fast_select = '0; int_enable = '1;
      slot_wr = 1'b0; slot_wr_index = '0; slot_wr_chan = '0;
      slot_wr_en = 1'b0; slot_wr_addr = '0; default_wr = 1'b0;
      default_addr = '0;
      repeat (16) @(negedge sys_clk);
      nrst = 1'b1;
      @(negedge sys_clk);
      chk_word(vector_addr, RST_ADDR);
      default_wr = 1'b1;
      default_addr = DEF_A;
      @(negedge sys_clk);
      default_wr = 1'b0;
      // every source alone: channel map and the non-vectored path
      for (i = 0; i < 62; i++) begin
         src = 62'h1 << i;
         settle();
         exp = 32'h1 << chan_of(i);
         chk_word(raw_status, exp);
         chk_word(normal_status, exp);
         chk_bit(normal_request, 1'b1);
         chk_bit(fast_request, 1'b0);
         chk_word(vector_addr, DEF_A);
         chk_bit(vector_valid, 1'b0);
      end
      // fast class beside vectored slots
      src = 62'h11;
      fast_select = 32'h0000_0010;
      wr_slot(4'h0, 5'h04, 1'b1, 32'h0000_A000);
      wr_slot(4'h1, 5'h00, 1'b1, 32'h0000_B000);
      settle();
      chk_bit(fast_request, 1'b1);
      chk_word(fast_status, 32'h0000_0010);
      chk_word(normal_status, 32'h0000_0001);
      chk_word(vector_addr, 32'h0000_B000);
      chk_word({30'h0, core_mode}, 32'h2);
      // two fast sources share the line and leave the slots
      fast_select = 32'h0000_0011;
      settle();
      chk_word(fast_status, 32'h0000_0011);
      chk_bit(normal_request, 1'b0);
      chk_bit(vector_valid, 1'b0);
      fast_select = '0;
      settle();
      chk_word(vector_addr, 32'h0000_A000);
      chk_word({28'h0, vector_slot}, 32'h0);
      chk_word(jump_addr, 32'h0000_A000);
      int_enable[4] = 1'b0;
      settle();
      chk_word(vector_addr, 32'h0000_B000);
      wr_slot(4'h1, 5'h00, 1'b0, 32'h0000_B000);
      settle();
      chk_word(vector_addr, DEF_A);
      chk_bit(vector_valid, 1'b0);
      wr_slot(4'hF, 5'h00, 1'b1, 32'h0000_F000);
      settle();
      chk_word({28'h0, vector_slot}, 32'hF);
      wr_slot(4'h3, 5'h00, 1'b1, 32'h0000_3000);
      settle();
      chk_word(vector_addr, 32'h0000_3000);
      // mid-run reset empties the slot table and the default address
      nrst = 1'b0;
      repeat (2) @(negedge sys_clk);
      nrst = 1'b1;
      settle();
      chk_bit(vector_valid, 1'b0);
      chk_word(vector_addr, RST_ADDR);
      chk_word({28'h0, vector_slot}, 32'h0);
      chk_bit(normal_request, 1'b1);
      src = '0;
      settle();
      chk_bit(normal_request, 1'b0);
      finish_test();
   end
endmodule
`default_nettype wire
